// >>> rtl/bcrs_pkg.sv
/*
 * Constants for the boot clock and reset sequencer: settling time,
 * reset vector, direct segment window and boot memory select decode.
 * Assumes a single 100 MHz primary clock; clock controls are software-written after boot.
 */
package bcrs_pkg;
    // Oscillator settling time in microseconds
    localparam int OSC_SETTLE_US = 1000;
    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 10000;
    // Settling time as cycles, rounded up
    localparam int OSC_SETTLE_CYC =
        (OSC_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Reset vector, virtual
    localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;
    // Direct segment virtual base and size
    localparam logic [31:0] SEG_BASE = 32'hA000_0000;
    localparam logic [31:0] SEG_SIZE = 32'h2000_0000;
    // Physical window reached through the segment
    localparam logic [31:0] PHYS_BASE = 32'h0000_0000;
    // Size of the boot memory select window
    localparam logic [31:0] BOOT_SEL_SIZE = 32'h0400_0000;
    // Number of PLLs and peripheral clocks
    localparam int NUM_PLL = 2;
    localparam int NUM_PCLK = 8;
    // Strap level meaning crystal attached (active low enable)
    localparam logic STRAP_CRYSTAL = 1'b0;
    // Reset value of clock controls
    localparam logic [NUM_PLL-1:0] PLL_EN_RST = '0;
    localparam logic [NUM_PCLK-1:0] CLK_RUN_RST = '1;
    localparam logic [NUM_PCLK-1:0] CLK_DIV_RST = '0;
endpackage : bcrs_pkg

// >>> rtl/bcrs_top.sv
/*
 * Boot sequencer: waits for power good, optionally waits for crystal
 * settling, then releases the core reset synchronously and presents the
 * virtual reset vector, and translates fetch addresses through the direct segment.
 * Assumes power good and strap are asynchronous pin levels; the core
 * drives the clock control requests after boot.
 */
`timescale 1ns/1ps
module bcrs_top
    import bcrs_pkg::*;
#(
    parameter int SETTLE_CYC = OSC_SETTLE_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_stable,
    input wire logic oscillator_mode_strap,
    input wire logic [31:0] fetch_vaddr,
    input wire logic fetch_req,
    input wire logic cfg_we,
    input wire logic [NUM_PLL-1:0] cfg_pll_en,
    input wire logic [NUM_PCLK-1:0] cfg_clk_run,
    input wire logic [NUM_PCLK-1:0] cfg_clk_div,
    output logic core_rst_n,
    output logic [31:0] boot_fetch_addr,
    output logic [31:0] fetch_paddr,
    output logic boot_memory_select,
    output logic seg_hit,
    output logic [NUM_PLL-1:0] pll_en,
    output logic [NUM_PCLK-1:0] clk_run,
    output logic [NUM_PCLK-1:0] clk_div
);
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_POWER = 4'h1,
        ST_STRAP = 4'h2,
        ST_SETTLE = 4'h4,
        ST_RUN = 4'h8
    } bcrs_state_e;

    // Whole module state
    typedef struct packed {
        logic pwr_s1;
        logic pwr_s2;
        logic strap_s1;
        logic strap_s2;
        logic crystal;
        bcrs_state_e st;
        logic [31:0] cnt;
        logic core_rst_n;
        logic [31:0] boot_addr;
        logic [31:0] paddr;
        logic sel;
        logic hit;
        logic [NUM_PLL-1:0] pll_en;
        logic [NUM_PCLK-1:0] clk_run;
        logic [NUM_PCLK-1:0] clk_div;
    } bcrs_s;

    bcrs_s st_ff; // Registered state
    bcrs_s nxt_st; // Next state

    // Direct segment hit test
    function automatic logic in_seg(input logic [31:0] va);
        in_seg = (va >= SEG_BASE) && ((va - SEG_BASE) < SEG_SIZE);
    endfunction : in_seg

    // Segment translation to physical
    function automatic logic [31:0] seg_xlate(input logic [31:0] va);
        seg_xlate = (va - SEG_BASE) + PHYS_BASE;
    endfunction : seg_xlate

    // Next state logic
    always_comb begin
        nxt_st = st_ff;
        // Two-stage synchronisers
        nxt_st.pwr_s1 = power_stable;
        nxt_st.pwr_s2 = st_ff.pwr_s1;
        nxt_st.strap_s1 = oscillator_mode_strap;
        nxt_st.strap_s2 = st_ff.strap_s1;
        unique case (st_ff.st)
            ST_POWER: begin
                // Hold reset until power good
                nxt_st.core_rst_n = 1'b0;
                if (st_ff.pwr_s2) begin
                    nxt_st.st = ST_STRAP;
                end
            end
            ST_STRAP: begin
                // Sample the strap once, after sync
                nxt_st.crystal = (st_ff.strap_s2 == STRAP_CRYSTAL);
                nxt_st.cnt = '0;
                if (!st_ff.pwr_s2) begin
                    nxt_st.st = ST_POWER;
                end else if (st_ff.strap_s2 == STRAP_CRYSTAL) begin
                    nxt_st.st = ST_SETTLE;
                end else begin
                    nxt_st.st = ST_RUN;
                    nxt_st.core_rst_n = 1'b1;
                end
            end
            ST_SETTLE: begin
                // Count crystal settling cycles
                if (!st_ff.pwr_s2) begin
                    nxt_st.st = ST_POWER;
                end else if (st_ff.cnt >= 32'(SETTLE_CYC - 1)) begin
                    nxt_st.st = ST_RUN;
                    nxt_st.core_rst_n = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
                end
            end
            ST_RUN: begin
                // Power loss drops back into reset
                if (!st_ff.pwr_s2) begin
                    nxt_st.st = ST_POWER;
                    nxt_st.core_rst_n = 1'b0;
                end
            end
            default: begin
                // Illegal code recovers to power wait
                nxt_st.st = ST_POWER;
                nxt_st.core_rst_n = 1'b0;
            end
        endcase
        // Fetch path: boot vector, then segment decode
        nxt_st.boot_addr = RESET_VECTOR;
        nxt_st.hit = fetch_req && in_seg(fetch_vaddr);
        nxt_st.paddr = in_seg(fetch_vaddr) ?
            seg_xlate(fetch_vaddr) : fetch_vaddr;
        nxt_st.sel = nxt_st.hit &&
            (nxt_st.paddr < BOOT_SEL_SIZE);
        // Clock controls: defaults in reset, software after
        if (!st_ff.core_rst_n) begin
            nxt_st.pll_en = PLL_EN_RST;
            nxt_st.clk_run = CLK_RUN_RST;
            nxt_st.clk_div = CLK_DIV_RST;
        end else if (cfg_we) begin
            nxt_st.pll_en = cfg_pll_en;
            nxt_st.clk_run = cfg_clk_run;
            nxt_st.clk_div = cfg_clk_div;
        end
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= '{pwr_s1: 1'b0, pwr_s2: 1'b0, strap_s1: 1'b0,
                strap_s2: 1'b0, crystal: 1'b0, st: ST_POWER,
                cnt: 32'h0000_0000, core_rst_n: 1'b0,
                boot_addr: RESET_VECTOR, paddr: 32'h0000_0000,
                sel: 1'b0, hit: 1'b0, pll_en: PLL_EN_RST,
                clk_run: CLK_RUN_RST, clk_div: CLK_DIV_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign core_rst_n = st_ff.core_rst_n;
    assign boot_fetch_addr = st_ff.boot_addr;
    assign fetch_paddr = st_ff.paddr;
    assign boot_memory_select = st_ff.sel;
    assign seg_hit = st_ff.hit;
    assign pll_en = st_ff.pll_en;
    assign clk_run = st_ff.clk_run;
    assign clk_div = st_ff.clk_div;

    // Core stays in reset while power not good
    property p_hold_power;
        @(posedge mclk) disable iff (!rst_n)
        !st_ff.pwr_s2 |=> !core_rst_n;
    endproperty
    a_hold_power: assert property (p_hold_power)
        else $error("core reset released without power");

    // External clock releases two cycles after power sync
    property p_ext_fast;
        @(posedge mclk) disable iff (!rst_n)
        (st_ff.st == ST_STRAP && st_ff.pwr_s2 &&
            st_ff.strap_s2 != STRAP_CRYSTAL) |=> core_rst_n;
    endproperty
    a_ext_fast: assert property (p_ext_fast)
        else $error("external clock release delayed");

    // Crystal path waits in settle state
    property p_xtal_wait;
        @(posedge mclk) disable iff (!rst_n)
        (st_ff.st == ST_STRAP && st_ff.pwr_s2 &&
            st_ff.strap_s2 == STRAP_CRYSTAL) |=> !core_rst_n [*2];
    endproperty
    a_xtal_wait: assert property (p_xtal_wait)
        else $error("crystal release without settling");

    // Settle counter reaches limit before release
    property p_settle_done;
        @(posedge mclk) disable iff (!rst_n)
        ($rose(core_rst_n) && st_ff.crystal) |->
            $past(st_ff.cnt) >= 32'(SETTLE_CYC - 1);
    endproperty
    a_settle_done: assert property (p_settle_done)
        else $error("released before settle count");

    // PLLs off and clocks undivided from one cycle after core reset asserts
    property p_clk_default;
        @(posedge mclk) disable iff (!rst_n)
        !core_rst_n |=> (pll_en == PLL_EN_RST) &&
            (clk_run == CLK_RUN_RST) && (clk_div == CLK_DIV_RST);
    endproperty
    a_clk_default: assert property (p_clk_default)
        else $error("clock controls not at default");

    // Reset vector constant
    property p_vector;
        @(posedge mclk) disable iff (!rst_n)
        core_rst_n |-> boot_fetch_addr == 32'hA000_0000;
    endproperty
    a_vector: assert property (p_vector)
        else $error("wrong reset vector");

    // Segment translation one cycle later
    property p_xlate;
        @(posedge mclk) disable iff (!rst_n)
        (fetch_req && fetch_vaddr == 32'hA000_0000) |=>
            (seg_hit && fetch_paddr == 32'h0000_0000 &&
            boot_memory_select);
    endproperty
    a_xlate: assert property (p_xlate)
        else $error("reset fetch not on boot memory");

    // Software updates apply after release
    property p_sw_cfg;
        @(posedge mclk) disable iff (!rst_n)
        (core_rst_n && cfg_we) |=> pll_en == $past(cfg_pll_en);
    endproperty
    a_sw_cfg: assert property (p_sw_cfg)
        else $error("pll enable not updated");

    // Peripheral run and divide controls follow a write, both fields together
    property p_sw_div;
        @(posedge mclk) disable iff (!rst_n)
        (core_rst_n && cfg_we) |=> (clk_run == $past(cfg_clk_run)) &&
            (clk_div == $past(cfg_clk_div));
    endproperty
    a_sw_div: assert property (p_sw_div)
        else $error("peripheral clock controls not updated");

    // Released core sees default clocks on every boot
    property p_release_defaults;
        @(posedge mclk) disable iff (!rst_n)
        $rose(core_rst_n) |-> (pll_en == PLL_EN_RST) &&
            (clk_run == CLK_RUN_RST) && (clk_div == CLK_DIV_RST);
    endproperty
    a_release_defaults: assert property (p_release_defaults)
        else $error("clock controls not at default on release");

    // Core reset is high only in the run state
    property p_run_only;
        @(posedge mclk) disable iff (!rst_n)
        core_rst_n |-> (st_ff.st == ST_RUN);
    endproperty
    a_run_only: assert property (p_run_only)
        else $error("core reset released outside run state");

    // Strap changes after boot leave the core running
    property p_strap_ignored;
        @(posedge mclk) disable iff (!rst_n)
        (core_rst_n && st_ff.pwr_s2) |=> core_rst_n;
    endproperty
    a_strap_ignored: assert property (p_strap_ignored)
        else $error("core reset dropped while power stable");

    // Fetch outside the segment passes through unselected
    property p_xlate_miss;
        @(posedge mclk) disable iff (!rst_n)
        (fetch_req && ((fetch_vaddr < SEG_BASE) ||
            (fetch_vaddr >= (SEG_BASE + SEG_SIZE)))) |=>
            (!seg_hit && !boot_memory_select &&
            (fetch_paddr == $past(fetch_vaddr)));
    endproperty
    a_xlate_miss: assert property (p_xlate_miss)
        else $error("fetch outside segment translated");

    // State register keeps its one-hot coding
    property p_state_onehot;
        @(posedge mclk) disable iff (!rst_n)
        $onehot(st_ff.st);
    endproperty
    a_state_onehot: assert property (p_state_onehot)
        else $error("sequencer state not one-hot");
endmodule : bcrs_top

// >>> dv/bcrs_board_model.sv
/* Board side model: power detector, oscillator strap and boot memory.
   Assumes the bench asks for power and strap; the design decodes select. */
`timescale 1ns/1ps
module bcrs_board_model (
    input wire logic mclk,
    input wire logic power_on,
    input wire logic use_crystal,
    input wire logic boot_memory_select,
    input wire logic [31:0] fetch_paddr,
    output logic power_stable,
    output logic oscillator_mode_strap,
    output logic [31:0] boot_data
);
    // Static strap level, low means crystal fitted
    assign oscillator_mode_strap = ~use_crystal;
    // Detector reports stable once the bench powers up
    assign power_stable = power_on;
    // Boot code only when selected, a toggling pattern otherwise
    initial boot_data = 32'h5A5A_5A5A;
    always @(posedge mclk) begin
        if (boot_memory_select) begin
            boot_data <= 32'hC0DE_0000 ^ fetch_paddr;
        end else begin
            boot_data <= ~boot_data;
        end
    end
endmodule : bcrs_board_model

// >>> dv/bcrs_top_bench.sv
/* Self-checking bench for the boot sequencer with a board model.
   Assumes a 100 MHz clock and a short settling count in simulation. */
`timescale 1ns/1ps
module bcrs_top_bench;
    import bcrs_pkg::*;
    localparam int SETTLE = 8;
    logic mclk, rst_n, power_on, use_crystal, fetch_req, cfg_we;
    logic power_stable, oscillator_mode_strap, core_rst_n;
    logic boot_memory_select, seg_hit;
    logic [31:0] fetch_vaddr, boot_fetch_addr, fetch_paddr, boot_data;
    logic [NUM_PLL-1:0] cfg_pll_en, pll_en;
    logic [NUM_PCLK-1:0] cfg_clk_run, cfg_clk_div, clk_run, clk_div;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    bcrs_top #(.SETTLE_CYC(SETTLE)) bcrs_top_i (.mclk(mclk), .rst_n(rst_n),
        .power_stable(power_stable),
        .oscillator_mode_strap(oscillator_mode_strap),
        .fetch_vaddr(fetch_vaddr), .fetch_req(fetch_req), .cfg_we(cfg_we),
        .cfg_pll_en(cfg_pll_en), .cfg_clk_run(cfg_clk_run),
        .cfg_clk_div(cfg_clk_div), .core_rst_n(core_rst_n),
        .boot_fetch_addr(boot_fetch_addr), .fetch_paddr(fetch_paddr),
        .boot_memory_select(boot_memory_select), .seg_hit(seg_hit),
        .pll_en(pll_en), .clk_run(clk_run), .clk_div(clk_div));
    bcrs_board_model bcrs_board_model_i (.mclk(mclk), .power_on(power_on),
        .use_crystal(use_crystal), .boot_memory_select(boot_memory_select),
        .fetch_paddr(fetch_paddr), .power_stable(power_stable),
        .oscillator_mode_strap(oscillator_mode_strap), .boot_data(boot_data));
    // Free running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Clock controls at their start-up state
    task automatic chk_defaults();
        chk("pll_en", 32'(PLL_EN_RST), 32'(pll_en));
        chk("clk_run", 32'(CLK_RUN_RST), 32'(clk_run));
        chk("clk_div", 32'(CLK_DIV_RST), 32'(clk_div));
    endtask : chk_defaults
    task automatic cfg_write(logic [1:0] p, logic [7:0] r, logic [7:0] d);
        cfg_we = 1'b1;
        cfg_pll_en = p;
        cfg_clk_run = r;
        cfg_clk_div = d;
        @(negedge mclk);
        cfg_we = 1'b0;
        // Idle cycle so a following write never reassigns the strobe
        @(negedge mclk);
    endtask : cfg_write
    // Power up and count edges until the core leaves reset
    task automatic power_up(logic xtal, int exp_edges);
        int n;
        n = 0;
        use_crystal = xtal;
        power_on = 1'b1;
        while (core_rst_n !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        chk("release edges", 32'(exp_edges), 32'(n));
    endtask : power_up
    task automatic t_config();
        chk_defaults();
        cfg_write(2'h3, 8'h00, 8'hFF);
        chk_defaults();
        power_up(1'b0, 4);
        cfg_write(2'h3, 8'h0F, 8'hA5);
        chk("cfg", 32'h0003_0FA5,
            {14'h0, pll_en, clk_run, clk_div});
        cfg_write(2'h1, 8'hF0, 8'h5A);
        chk("cfg", 32'h0001_F05A,
            {14'h0, pll_en, clk_run, clk_div});
    endtask : t_config
    task automatic fetch(logic [31:0] va);
        logic hit;
        logic [31:0] pa;
        hit = (va - SEG_BASE) < SEG_SIZE;
        pa = hit ? va - SEG_BASE + PHYS_BASE : va;
        fetch_req = 1'b1;
        fetch_vaddr = va;
        @(negedge mclk);
        fetch_req = 1'b0;
        chk("seg_hit", 32'(hit), 32'(seg_hit));
        chk("paddr", pa, fetch_paddr);
        chk("select", 32'(hit && pa < BOOT_SEL_SIZE),
            32'(boot_memory_select));
        @(negedge mclk);
        if (hit && pa < BOOT_SEL_SIZE) begin
            chk("boot data", 32'hC0DE_0000 ^ pa, boot_data);
        end
    endtask : fetch
    task automatic t_fetch();
        chk("vector", 32'hA000_0000, boot_fetch_addr);
        fetch(boot_fetch_addr);
        fetch(32'hA3FF_FFFC);
        fetch(32'hA400_0000);
        fetch(32'hBFFF_FFFC);
        fetch(32'hC000_0000);
        fetch(32'h9FFF_FFFC);
    endtask : t_fetch
    task automatic t_crystal();
        power_on = 1'b0;
        repeat (6) @(negedge mclk);
        chk("power loss", 32'h0, 32'(core_rst_n));
        power_up(1'b1, 4 + SETTLE);
        use_crystal = 1'b0;
        repeat (4) @(negedge mclk);
        chk("strap late", 32'h1, 32'(core_rst_n));
    endtask : t_crystal
    initial begin
        rst_n = 1'b0;
        power_on = 1'b0;
        use_crystal = 1'b0;
        fetch_req = 1'b0;
        fetch_vaddr = 32'h0;
        cfg_we = 1'b0;
        cfg_pll_en = '0;
        cfg_clk_run = '0;
        cfg_clk_div = '0;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_config();
        t_fetch();
        t_crystal();
        wrap_up();
    end
endmodule : bcrs_top_bench
